// File: core/ats_pkg.sv
// constants, field layout and state codes of the auto-trigger sequencer
package ats_pkg;
   // ---------------------------------------------
   // register byte offsets
   // ---------------------------------------------
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_CHAN = 8'h04;
   localparam logic [7:0] OFS_TIMER = 8'h08;
   localparam logic [7:0] OFS_STAT = 8'h0c;
   localparam logic [7:0] OFS_ACC1 = 8'h10;
   localparam logic [7:0] OFS_ACC2 = 8'h14;
   // ---------------------------------------------
   // field positions
   // ---------------------------------------------
   localparam int CTL_START = 0;
   localparam int CTL_TSEL = 1;
   localparam int CTL_COUNT = 3;
   localparam int CTL_TWO = 6;
   localparam int CTL_BSRC = 7;
   localparam int CTL_REF = 8;
   localparam int CTL_CKS = 10;
   localparam int CTL_GAP = 13;
   localparam int CTL_BLANK = 17;
   localparam int CTL_W = 23;
   localparam int CH_TYPE1 = 0;
   localparam int CH_SEL1 = 1;
   localparam int CH_TYPE2 = 5;
   localparam int CH_SEL2 = 6;
   localparam int CH_W = 10;
   localparam int TM_PRE = 0;
   localparam int TM_EXT = 16;
   localparam int TM_CKS = 17;
   localparam int TM_RUN = 18;
   localparam int TM_W = 18;
   localparam int ST_BUSY = 0;
   localparam int ST_IRQ = 1;
   localparam int ST_RPT = 2;
   localparam int ST_CNT = 4;
   // ---------------------------------------------
   // reset values, codes, timing
   // ---------------------------------------------
   localparam logic [CTL_W-1:0] CTRL_RST = 23'h000000;
   localparam logic [CH_W-1:0] CHAN_RST = 10'h000;
   localparam logic [TM_W-1:0] TIMER_RST = 18'h00000;
   localparam logic [1:0] TRIG_BLANK = 2'h0;
   localparam logic [1:0] TRIG_OVP_TIMER = 2'h1;
   localparam logic [1:0] TRIG_SW_TIMER = 2'h2;
   localparam logic [1:0] TRIG_SW_NOW = 2'h3;
   localparam int CONV_PERIODS = 16;
   localparam logic [15:0] TIMER_FULL = 16'hffff;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_DECERR = 2'h3;

   typedef enum logic [5:0] {
      S_IDLE = 6'b000001,
      S_ARMED = 6'b000010,
      S_BLANK = 6'b000100,
      S_TIMRUN = 6'b001000,
      S_CONV = 6'b010000,
      S_GAP = 6'b100000
   } ats_state_t;
endpackage

// File: core/ats_edge_rise.sv
// registered rising-edge detector for a synchronous trigger level
`timescale 1ns/1ps
module ats_edge_rise import ats_pkg::*; (
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic level,
   output logic rise
);
   logic prevQ;

   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         prevQ <= 1'b0;
         rise <= 1'b0;
      end else begin
         prevQ <= level;
         rise <= level & ~prevQ;
      end
   end
endmodule

// File: core/ats_conv_unit.sv
// conversion timing unit: 16 converter periods, result taken at the end
`timescale 1ns/1ps
module ats_conv_unit import ats_pkg::*; #(
   parameter int RES_W = 12
) (
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic startConv,
   input wire logic [2:0] clockSel,
   input wire logic [RES_W-1:0] sampleData,
   output logic busy,
   output logic done,
   output logic [RES_W-1:0] result
);
   // converter period is 2^clockSel system clocks
   logic [10:0] cntQ;
   logic [10:0] loadVal;

   assign loadVal = 11'((CONV_PERIODS << clockSel) - 1);

   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         busy <= 1'b0;
         done <= 1'b0;
         cntQ <= 11'h000;
         result <= '0;
      end else begin
         done <= 1'b0;
         if (startConv && !busy) begin
            busy <= 1'b1;
            cntQ <= loadVal;
         end else if (busy) begin
            if (cntQ == 11'h000) begin
               busy <= 1'b0;
               done <= 1'b1;
               result <= sampleData;
            end else begin
               cntQ <= cntQ - 11'h001;
            end
         end
      end
   end
endmodule

// File: core/ats_sequencer.sv
// auto-trigger conversion sequencer with AXI4-Lite register slave
//
// Register access over AXI4-Lite and the address map were left to the implementer.
`timescale 1ns/1ps
module ats_sequencer import ats_pkg::*; #(
   parameter int RES_W = 12,
   parameter int ACC_W = 16
) (
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic periodicTimerOutputA,
   input wire logic periodicTimerOutputB,
   input wire logic overvoltageEvent,
   input wire logic [RES_W-1:0] sampleData,
   output logic conversionBusy,
   output logic converterIrqFlag,
   output logic timerRunning,
   output logic autoChannelSourceType,
   output logic [3:0] autoChannelInputSelect,
   output logic [1:0] referenceSelect
);
   // ---------------------------------------------
   // storage and decoded fields
   // ---------------------------------------------
   ats_state_t stateQ, stateD;
   logic [CTL_W-1:0] ctrlQ;
   logic [CH_W-1:0] chanQ;
   logic [TM_W-1:0] timerCfgQ;
   logic startQ, rptQ, chanIdxQ, convStartQ, tickQ;
   logic [2:0] cntQ;
   logic [5:0] blankCntQ;
   logic [3:0] gapCntQ;
   logic [15:0] timerQ;
   logic [ACC_W-1:0] acc1Q, acc2Q;
   logic awHeldQ, wHeldQ;
   logic [7:0] awAddrQ;
   logic [31:0] wDataQ, wMask, rdMux;
   logic [3:0] wStrbQ;
   logic doWrite, wrCtrl, wrChan, wrTimer, wrStat, mapped;
   logic [31:0] newCtrl;
   logic armReq, convDone, convBusy, cycleEnd, groupDone, twoCh;
   logic blankLevel, blankEdge, ovpEdge, ovpStart, trigEdge, timerOvf;
   logic [RES_W-1:0] convResult;
   logic [1:0] tsel;

   assign tsel = ctrlQ[CTL_TSEL +: 2];
   // two-channel needs a nonzero count; arming already demands one
   assign twoCh = ctrlQ[CTL_TWO];
   // ---------------------------------------------
   // trigger sources
   // ---------------------------------------------
   // blanking source select
   assign blankLevel = ctrlQ[CTL_BSRC] ? periodicTimerOutputB : periodicTimerOutputA;

   ats_edge_rise u_blank_edge (
      .clk_sys(clk_sys),
      .resetn(resetn),
      .level(blankLevel),
      .rise(blankEdge)
   );

   ats_edge_rise u_ovp_edge (
      .clk_sys(clk_sys),
      .resetn(resetn),
      .level(overvoltageEvent),
      .rise(ovpEdge)
   );

   assign ovpStart = ovpEdge && timerCfgQ[TM_EXT];
   assign trigEdge = (tsel == TRIG_BLANK) ? blankEdge :
                     (tsel == TRIG_OVP_TIMER) ? ovpStart : 1'b0;
   assign timerOvf = tickQ && (timerQ == TIMER_FULL);
   // ---------------------------------------------
   // conversion unit
   // ---------------------------------------------
   ats_conv_unit #(.RES_W(RES_W)) u_conv (
      .clk_sys(clk_sys),
      .resetn(resetn),
      .startConv(convStartQ),
      .clockSel(ctrlQ[CTL_CKS +: 3]),
      .sampleData(sampleData),
      .busy(convBusy),
      .done(convDone),
      .result(convResult)
   );

   assign conversionBusy = convBusy;
   assign cycleEnd = convDone && (!twoCh || chanIdxQ);
   assign groupDone = cycleEnd && ((cntQ + 3'h1) == ctrlQ[CTL_COUNT +: 3]);
   // ---------------------------------------------
   // register bus write side
   // ---------------------------------------------
   assign doWrite = awHeldQ && wHeldQ && !s_axi_bvalid;
   assign wMask = {{8{wStrbQ[3]}}, {8{wStrbQ[2]}}, {8{wStrbQ[1]}}, {8{wStrbQ[0]}}};
   assign wrCtrl = doWrite && (awAddrQ == OFS_CTRL);
   assign wrChan = doWrite && (awAddrQ == OFS_CHAN);
   assign wrTimer = doWrite && (awAddrQ == OFS_TIMER);
   assign wrStat = doWrite && (awAddrQ == OFS_STAT);
   assign mapped = (awAddrQ == OFS_CTRL) || (awAddrQ == OFS_CHAN) ||
                   (awAddrQ == OFS_TIMER) || (awAddrQ == OFS_STAT) ||
                   (awAddrQ == OFS_ACC1) || (awAddrQ == OFS_ACC2);
   assign newCtrl = ({9'h000, ctrlQ} & ~wMask) | (wDataQ & wMask);
   // arm on start bit rising only
   assign armReq = wrCtrl && newCtrl[CTL_START] && !startQ && (stateQ == S_IDLE) &&
                   (newCtrl[CTL_COUNT +: 3] != 3'h0);

   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         awHeldQ <= 1'b0;
         wHeldQ <= 1'b0;
         awAddrQ <= 8'h00;
         wDataQ <= 32'h00000000;
         wStrbQ <= 4'h0;
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            awHeldQ <= 1'b1;
            awAddrQ <= {s_axi_awaddr[7:2], 2'h0};
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wHeldQ <= 1'b1;
            wDataQ <= s_axi_wdata;
            wStrbQ <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
         end
         if (doWrite) begin
            awHeldQ <= 1'b0;
            wHeldQ <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= mapped ? RESP_OKAY : RESP_DECERR;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // configuration registers; start bit handled on its own
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         ctrlQ <= CTRL_RST;
         chanQ <= CHAN_RST;
         timerCfgQ <= TIMER_RST;
      end else begin
         if (wrCtrl) ctrlQ <= {newCtrl[CTL_W-1:1], 1'b0};
         if (wrChan) chanQ <= chanQ & ~wMask[CH_W-1:0] | wDataQ[CH_W-1:0] & wMask[CH_W-1:0];
         if (wrTimer) begin
            timerCfgQ <= timerCfgQ & ~wMask[TM_W-1:0] | wDataQ[TM_W-1:0] & wMask[TM_W-1:0];
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         startQ <= 1'b0;
      // hardware clears start at group end
      end else if (groupDone) begin
         startQ <= 1'b0;
      end else if (armReq) begin
         startQ <= 1'b1;
      end else if (wrCtrl && !newCtrl[CTL_START]) begin
         startQ <= 1'b0;
      end
   end
   // ---------------------------------------------
   // sequencer state
   // ---------------------------------------------
   always_comb begin
      stateD = stateQ;
      unique case (stateQ)
         S_IDLE: begin
            if (armReq) begin
               stateD = (newCtrl[CTL_TSEL +: 2] == TRIG_SW_NOW) ? S_CONV :
                        (newCtrl[CTL_TSEL +: 2] == TRIG_SW_TIMER) ? S_TIMRUN : S_ARMED;
            end
         end
         S_ARMED: begin
            if (!startQ) stateD = S_IDLE;
            else if (tsel == TRIG_BLANK && blankEdge) stateD = S_BLANK;
            else if (tsel == TRIG_OVP_TIMER && ovpStart) stateD = S_TIMRUN;
         end
         S_BLANK: begin
            if (!startQ) stateD = S_IDLE;
            else if (blankCntQ == 6'h00) stateD = S_CONV;
         end
         S_TIMRUN: begin
            if (!startQ) stateD = S_IDLE;
            else if (timerOvf) stateD = S_CONV;
         end
         S_CONV: begin
            if (convDone) begin
               if (!startQ || groupDone) stateD = S_IDLE;
               else if ((twoCh && !chanIdxQ) || tsel == TRIG_SW_NOW) stateD = S_GAP;
               else if (tsel == TRIG_SW_TIMER) stateD = S_TIMRUN;
               else stateD = S_ARMED;
            end
         end
         S_GAP: begin
            if (!startQ) stateD = S_IDLE;
            else if (gapCntQ == 4'h0) stateD = S_CONV;
         end
         default: stateD = S_IDLE;
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         stateQ <= S_IDLE;
         convStartQ <= 1'b0;
      end else begin
         stateQ <= stateD;
         convStartQ <= (stateD == S_CONV) && (stateQ != S_CONV);
      end
   end

   // blanking, interval and trigger timer counters
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         blankCntQ <= 6'h00;
         gapCntQ <= 4'h0;
         timerQ <= 16'h0000;
         tickQ <= 1'b0;
         timerRunning <= 1'b0;
      end else begin
         blankCntQ <= (stateD == S_BLANK && stateQ != S_BLANK) ? ctrlQ[CTL_BLANK +: 6] :
                      (blankCntQ != 6'h00) ? blankCntQ - 6'h01 : 6'h00;
         gapCntQ <= (stateD == S_GAP && stateQ != S_GAP) ? ctrlQ[CTL_GAP +: 4] :
                    (gapCntQ != 4'h0) ? gapCntQ - 4'h1 : 4'h0;
         // slow timer clock ticks every second cycle
         tickQ <= timerCfgQ[TM_CKS] ? ~tickQ : 1'b1;
         if (stateD == S_TIMRUN && stateQ != S_TIMRUN) timerQ <= timerCfgQ[TM_PRE +: 16];
         else if (stateQ == S_TIMRUN && tickQ) timerQ <= timerQ + 16'h0001;
         timerRunning <= (stateD == S_TIMRUN);
      end
   end
   // ---------------------------------------------
   // channel routing, counting, accumulation, flags
   // ---------------------------------------------
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         chanIdxQ <= 1'b0;
         autoChannelSourceType <= 1'b0;
         autoChannelInputSelect <= 4'h0;
         referenceSelect <= 2'h0;
      end else begin
         if (armReq) chanIdxQ <= 1'b0;
         else if (convDone && twoCh) chanIdxQ <= ~chanIdxQ;
         if (convStartQ) begin
            autoChannelSourceType <= chanIdxQ ? chanQ[CH_TYPE2] : chanQ[CH_TYPE1];
            autoChannelInputSelect <= chanIdxQ ? chanQ[CH_SEL2 +: 4] : chanQ[CH_SEL1 +: 4];
         end
         referenceSelect <= ctrlQ[CTL_REF +: 2];
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         cntQ <= 3'h0;
         acc1Q <= '0;
         acc2Q <= '0;
      end else if (armReq) begin
         cntQ <= 3'h0;
         acc1Q <= '0;
         acc2Q <= '0;
      end else begin
         if (cycleEnd) cntQ <= cntQ + 3'h1;
         if (convDone && !chanIdxQ) acc1Q <= acc1Q + ACC_W'(convResult);
         if (convDone && chanIdxQ) acc2Q <= acc2Q + ACC_W'(convResult);
      end
   end

   // flags: hardware set wins over software clear
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         converterIrqFlag <= 1'b0;
         rptQ <= 1'b0;
      end else begin
         if (groupDone) converterIrqFlag <= 1'b1;
         else if (wrStat && wStrbQ[0] && wDataQ[ST_IRQ]) converterIrqFlag <= 1'b0;
         if ((stateQ == S_CONV || stateQ == S_GAP) && trigEdge) rptQ <= 1'b1;
         else if (armReq) rptQ <= 1'b0;
         else if (wrStat && wStrbQ[0] && wDataQ[ST_RPT]) rptQ <= 1'b0;
      end
   end
   // ---------------------------------------------
   // register bus read side
   // ---------------------------------------------
   always_comb begin
      unique case ({s_axi_araddr[7:2], 2'h0})
         OFS_CTRL: rdMux = {9'h000, ctrlQ[CTL_W-1:1], startQ};
         OFS_CHAN: rdMux = {22'h000000, chanQ};
         OFS_TIMER: rdMux = {13'h0000, timerRunning, timerCfgQ};
         OFS_STAT: rdMux = {25'h0000000, cntQ, 1'b0, rptQ, converterIrqFlag, convBusy};
         OFS_ACC1: rdMux = 32'(acc1Q);
         OFS_ACC2: rdMux = 32'(acc2Q);
         default: rdMux = 32'h00000000;
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rdMux;
         s_axi_rresp <= (rdMux == 32'h00000000 && s_axi_araddr[7:2] > 6'h05) ?
                        RESP_DECERR : RESP_OKAY;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end
   // ---------------------------------------------
   // assertions
   // ---------------------------------------------
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!resetn);

   property p_group_end;
      groupDone |=> !startQ && converterIrqFlag && stateQ == S_IDLE;
   endproperty
   a_group_end: assert property (p_group_end) else $error("group end missed");
   property p_no_restart;
      startQ && wrCtrl && newCtrl[CTL_START] |=> cntQ >= $past(cntQ) && acc1Q >= $past(acc1Q);
   endproperty
   a_no_restart: assert property (p_no_restart) else $error("group restarted");
   property p_abort_busy;
      stateQ == S_CONV && !startQ && !convDone |=> stateQ == S_CONV;
   endproperty
   a_abort_busy: assert property (p_abort_busy) else $error("busy abort early");
   property p_abort_idle;
      !startQ && (stateQ == S_BLANK || stateQ == S_GAP || stateQ == S_TIMRUN) |=> stateQ == S_IDLE;
   endproperty
   a_abort_idle: assert property (p_abort_idle) else $error("idle abort late");
   property p_rpt_clear;
      armReq |=> !rptQ && cntQ == 3'h0 && acc1Q == '0;
   endproperty
   a_rpt_clear: assert property (p_rpt_clear) else $error("arm did not clear");
   property p_conv_len;
      convStartQ && ctrlQ[CTL_CKS +: 3] == 3'h0 |-> ##17 convDone;
   endproperty
   a_conv_len: assert property (p_conv_len) else $error("conversion length");
   property p_ovf;
      stateQ == S_TIMRUN && startQ && timerOvf |=> stateQ == S_CONV ##1 convBusy && !timerRunning;
   endproperty
   a_ovf: assert property (p_ovf) else $error("overflow no convert");
   property p_blank;
      stateQ == S_ARMED && startQ && tsel == TRIG_BLANK && blankEdge |=> stateQ == S_BLANK;
   endproperty
   a_blank: assert property (p_blank) else $error("blanking not started");
   property p_ext_gate;
      stateQ == S_ARMED && tsel == TRIG_OVP_TIMER && !timerCfgQ[TM_EXT] |=> !timerRunning;
   endproperty
   a_ext_gate: assert property (p_ext_gate) else $error("timer started ungated");
   property p_acc1;
      convDone && !chanIdxQ && !armReq |=> acc1Q == $past(acc1Q) + ACC_W'($past(convResult));
   endproperty
   a_acc1: assert property (p_acc1) else $error("accumulate failed");

   c_group: cover property (groupDone);
   c_repeat: cover property ($rose(rptQ));
   c_abort: cover property (stateQ == S_CONV && !startQ ##[1:300] stateQ == S_IDLE);
endmodule

// File: test/ats_trigger_model.sv
// trigger source model: pwm outputs and overvoltage level pulses
`timescale 1ns/1ps
module ats_trigger_model (
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic [2:0] fire,
   output logic [2:0] level
);
   logic [2:0] fire_q;
   // two cycles high so one edge is never lost
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         fire_q <= '0;
         level <= '0;
      end else begin
         fire_q <= fire;
         level <= fire | fire_q;
      end
   end
endmodule

// File: test/ats_sequencer_tb.sv
// self-checking bench of the auto-trigger sequencer
`timescale 1ns/1ps
module ats_sequencer_tb import ats_pkg::*; ;
`define CHK(nm, e, g) begin n_compared++; if ((e) !== (g)) begin n_errors++; \
   $display("[ERR] %s exp %h got %h", nm, e, g); end end
   logic clk_sys = '0;
   logic resetn = '0;
   logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
   logic [31:0] s_axi_wdata = '0, s_axi_rdata, rv;
   logic [3:0] s_axi_wstrb = 4'hf, autoChannelInputSelect;
   logic s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_bready = '0;
   logic s_axi_arvalid = '0, s_axi_rready = '0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp, referenceSelect;
   logic [2:0] fire = '0, trig;
   logic [11:0] sampleData = '0, s;
   logic [9:0] ch;
   logic conversionBusy, converterIrqFlag, timerRunning, autoChannelSourceType;
   int n_errors = 0, n_compared = 0, cycles = 0, n;
   always #25 clk_sys = ~clk_sys;
   ats_sequencer uut (.clk_sys, .resetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .periodicTimerOutputA(trig[0]),
      .periodicTimerOutputB(trig[1]), .overvoltageEvent(trig[2]), .sampleData,
      .conversionBusy, .converterIrqFlag, .timerRunning, .autoChannelSourceType,
      .autoChannelInputSelect, .referenceSelect);
   ats_trigger_model model (.clk_sys, .resetn, .fire, .level(trig));
   // ---------------------------------------------
   // bus tasks and expectations
   // ---------------------------------------------
   task automatic cyc(int k);
      repeat (k) @(posedge clk_sys);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = RESP_OKAY);
      logic aw, w, b;
      b = '0;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= '1;
      while (!b) begin
         @(negedge clk_sys);
         aw = s_axi_awvalid && s_axi_awready;
         w = s_axi_wvalid && s_axi_wready;
         b = s_axi_bvalid;
         if (b) `CHK("bresp", er, s_axi_bresp)
         @(posedge clk_sys);
         if (aw) s_axi_awvalid <= '0;
         if (w) s_axi_wvalid <= '0;
      end
      s_axi_bready <= '0;
      // one edge between transfers so ready is never set twice at once
      @(posedge clk_sys);
   endtask
   task automatic rd(input logic [7:0] a, input logic [1:0] er = RESP_OKAY);
      logic ar, r;
      r = '0;
      s_axi_araddr <= a;
      {s_axi_arvalid, s_axi_rready} <= '1;
      while (!r) begin
         @(negedge clk_sys);
         ar = s_axi_arvalid && s_axi_arready;
         r = s_axi_rvalid;
         if (r) rv = s_axi_rdata;
         if (r) `CHK("rresp", er, s_axi_rresp)
         @(posedge clk_sys);
         if (ar) s_axi_arvalid <= '0;
      end
      s_axi_rready <= '0;
      @(posedge clk_sys);
   endtask
   // polls the start bit; the watchdog cuts a hang
   task automatic waitgrp();
      rv = 32'h1;
      while (rv[CTL_START]) rd(OFS_CTRL);
   endtask
   task automatic waitbusy(logic v);
      do @(negedge clk_sys); while (conversionBusy !== v);
      @(posedge clk_sys);
   endtask
   task automatic pulse(int i);
      fire[i] <= '1;
      cyc(1);
      fire <= '0;
      cyc(4);
   endtask
   function automatic logic [31:0] ctl(logic [1:0] ts, logic [2:0] c, logic tw, logic bs,
      logic [1:0] rf, logic [2:0] ck, logic [5:0] bl);
      return {9'h0, bl, 4'h2, ck, rf, bs, tw, c, ts, 1'h1};
   endfunction
   function automatic logic [15:0] acc(int k, logic [11:0] v);
      return 16'(k * v);
   endfunction
   task automatic test_done();
      $display("compared %0d errors %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 30000) begin
         n_errors++;
         test_done();
      end
   end
   // ---------------------------------------------
   // tests
   // ---------------------------------------------
   initial begin
      void'($urandom(32'h097a));
      cyc(16);
      resetn <= '1;
      cyc(1);
      wr(8'h20, '0, RESP_DECERR);
      rd(8'h20, RESP_DECERR);
      rd(OFS_CTRL);
      `CHK("ctrl_rst", 32'(CTRL_RST), rv)
      for (int m = 0; m < 4; m++) begin
         n = $urandom_range(7, 1);
         s = 12'($urandom);
         sampleData <= s;
         // slow timer clock in the software-timer mode
         wr(OFS_TIMER, m == 2 ? 32'h3ffc0 : 32'h1ffc0);
         wr(OFS_CTRL, ctl(2'(m), 3'(n), '0, '1, '0, '0, 6'h4));
         for (int k = 0; k < n && m < 2; k++) begin
            pulse(m == 0 ? 1 : 2);
            if (m == 1) `CHK("timer_run", 1'h1, timerRunning)
            waitbusy('1);
            waitbusy('0);
            cyc(3);
         end
         waitgrp();
         rd(OFS_ACC1);
         `CHK("acc1", acc(n, s), rv[15:0])
         `CHK("irq", 1'h1, converterIrqFlag)
         wr(OFS_STAT, 32'h6);
         `CHK("irq_clr", 1'h0, converterIrqFlag)
         $display("mode %0d group of %0d done", m, n);
      end
      ch = 10'($urandom);
      wr(OFS_CHAN, 32'(ch));
      // internal reference, slow clock as a sensor needs
      wr(OFS_CTRL, ctl(TRIG_SW_NOW, 3'h2, '1, '0, 2'h1, 3'h1, '0));
      `CHK("ref", 2'h1, referenceSelect)
      waitbusy('1);
      `CHK("type1", ch[0], autoChannelSourceType)
      `CHK("sel1", ch[4:1], autoChannelInputSelect)
      waitbusy('0);
      waitbusy('1);
      `CHK("type2", ch[5], autoChannelSourceType)
      `CHK("sel2", ch[9:6], autoChannelInputSelect)
      waitgrp();
      rd(OFS_ACC2);
      `CHK("acc2", acc(2, s), rv[15:0])
      $display("two-channel done");
      wr(OFS_CTRL, ctl(TRIG_BLANK, 3'h2, '0, '0, '0, '0, '0));
      pulse(0);
      waitbusy('1);
      pulse(0);
      rd(OFS_STAT);
      `CHK("rpt", 1'h1, rv[ST_RPT])
      waitbusy('0);
      // short wait: a wrongly kept edge would already be converting
      cyc(8);
      `CHK("no_conv", 1'h0, conversionBusy)
      pulse(0);
      waitgrp();
      wr(OFS_CTRL, ctl(TRIG_BLANK, 3'h1, '0, '0, '0, '0, 6'h3f));
      rd(OFS_STAT);
      `CHK("rpt_clr", 1'h0, rv[ST_RPT])
      pulse(0);
      wr(OFS_CTRL, '0);
      // lands where an unstopped blanking would be converting
      cyc(65);
      `CHK("abort_idle", 1'h0, conversionBusy)
      $display("repeat and abort done");
      wr(OFS_TIMER, 32'hffc0);
      wr(OFS_CTRL, ctl(TRIG_OVP_TIMER, 3'h1, '0, '0, '0, '0, '0));
      pulse(2);
      `CHK("no_ext", 1'h0, timerRunning)
      wr(OFS_CTRL, '0);
      wr(OFS_CTRL, ctl(TRIG_SW_NOW, 3'h7, '0, '0, '0, 3'h3, '0));
      waitbusy('1);
      // start again mid-group: must be ignored
      wr(OFS_CTRL, ctl(TRIG_SW_NOW, 3'h7, '0, '0, '0, 3'h3, '0));
      wr(OFS_CTRL, '0);
      `CHK("finish_conv", 1'h1, conversionBusy)
      waitbusy('0);
      cyc(40);
      `CHK("stopped", 1'h0, conversionBusy)
      $display("busy abort done");
      test_done();
   end
endmodule
